// ### design/coincidence_map.vh
`ifndef COINCIDENCE_MAP_VH
`define COINCIDENCE_MAP_VH

// Safety-function vector width carried by each link
`define N_FUNC          8
// Number of redundant divisional links
`define N_LINKS         4
// Clock rate in MHz
`define CLK_MHZ         25

// Frame check field
`define CRC_W           8
`define CRC_POLY        8'h07
`define CRC_INIT        8'h00

// Arrival timeout in microseconds, and cycles derived from it
`define TIMEOUT_US      10000
`define TIMEOUT_CYCLES  (`TIMEOUT_US * `CLK_MHZ)
// Voting cycle period in microseconds, and cycles derived from it
`define VOTE_US         100
`define VOTE_CYCLES     (`VOTE_US * `CLK_MHZ)
// Watchdog limit in microseconds, and cycles derived from it
`define WD_US           1000
`define WD_CYCLES       (`WD_US * `CLK_MHZ)

`endif

// ### design/vote_buffer.v
`timescale 1ns/1ps

module vote_buffer #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rst_sync_b,
    // Filling side
    input  wire             in_valid,
    input  wire [WIDTH-1:0] in_data,
    output wire             in_ready,
    // Draining side
    output reg              out_valid,
    output reg  [WIDTH-1:0] out_data,
    input  wire             out_ready
);

    reg             skid_valid;
    reg [WIDTH-1:0] skid_data;

    // Second entry only fills when the head is stalled
    assign in_ready = !skid_valid;

    // Head entry plus one spare, so a stall never drops a word
    always @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            out_valid  <= 1'b0;
            out_data   <= {WIDTH{1'b0}};
            skid_valid <= 1'b0;
            skid_data  <= {WIDTH{1'b0}};
        end else if (!out_valid || out_ready) begin
            if (skid_valid) begin
                out_valid  <= 1'b1;
                out_data   <= skid_data;
                skid_valid <= 1'b0;
            end else begin
                out_valid <= in_valid;
                out_data  <= in_data;
            end
        end else if (in_valid && !skid_valid) begin
            skid_valid <= 1'b1;
            skid_data  <= in_data;
        end
    end

endmodule // vote_buffer

// ### design/coincidence_receiver.v
// Function
// - Four independent one-way serial links, one per divisional_trip_controller, are each received separately.
// - Each message carries a Boolean vector with one initiation bit per engineered_safety_feature function.
// - Every received message is checked by CRC and by a data redundancy (inverted copy) check.
// - A message passing all checks is stored in the fixed storage slot of its link, read by the voter.
// - A message failing any check replaces that link's data with the predefined failure-state value.
// - An initiation is asserted when at least two of the four link vectors demand it.
// - Coincidence is the OR of the six pairs AB, AC, AD, BC, BD and CD.
// - A link with no new message within the timeout raises a link-failed alarm and is forced to a fixed value.
// - A detected message problem sets a per-link error status bit visible to the voter.
// - While a link's error bit is set the voter uses the failure-state value and an alarm is raised.
// - A watchdog supervises the cyclic processing and raises an annunciation when it is disturbed.
`timescale 1ns/1ps
`include "coincidence_map.vh"

module coincidence_receiver #(
    parameter                N_FUNC         = `N_FUNC,
    parameter [N_FUNC-1:0]   FAIL_STATE     = {N_FUNC{1'b1}},
    parameter                TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
    parameter                VOTE_CYCLES    = `VOTE_CYCLES,
    parameter                WD_CYCLES      = `WD_CYCLES
) (
    // Clock and reset
    input  wire                    clk_sys,
    input  wire                    rst_b,
    // Serial links, one per division, asynchronous pins
    input  wire [`N_LINKS-1:0]     link_line,
    input  wire [`N_LINKS-1:0]     link_frame,
    // Voted initiation stream
    output wire [N_FUNC-1:0]       init_data,
    output wire                    init_valid,
    input  wire                    init_ready,
    // Status and alarms
    output reg  [`N_LINKS-1:0]     link_fail_alarm,
    output reg  [`N_LINKS-1:0]     err_status,
    output reg                     err_alarm,
    output reg                     wd_alarm
);

    localparam NL         = `N_LINKS;
    localparam FRAME_BITS = 2 * N_FUNC + `CRC_W;
    localparam CW         = $clog2(FRAME_BITS + 1);

    // Reset release through two flops
    reg rst_meta_b;
    reg rst_sync_b;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // Pin synchronisers, stage one read only by stage two
    reg [NL-1:0] line_meta;
    reg [NL-1:0] line_sync;
    reg [NL-1:0] frame_meta;
    reg [NL-1:0] frame_sync;
    reg [NL-1:0] frame_prev;

    always @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            line_meta  <= 4'h0;
            line_sync  <= 4'h0;
            frame_meta <= 4'h0;
            frame_sync <= 4'h0;
            frame_prev <= 4'h0;
        end else begin
            line_meta  <= link_line;
            line_sync  <= line_meta;
            frame_meta <= link_frame;
            frame_sync <= frame_meta;
            frame_prev <= frame_sync;
        end
    end

    // Per-link results seen by the voter
    wire [NL-1:0]        err_w;
    wire [NL-1:0]        fail_w;
    wire [NL*N_FUNC-1:0] eff_flat;

    genvar gi;
    generate
        for (gi = 0; gi < NL; gi = gi + 1) begin : g_link
            reg  [`CRC_W-1:0]   crc;
            reg  [CW-1:0]       count;
            reg  [2*N_FUNC-1:0] payload;
            reg  [N_FUNC-1:0]   slot;
            reg                 err;
            reg                 fail;
            reg  [31:0]         silence;
            wire                start;
            wire                finish;
            wire                fb;
            wire                good;
            wire [`CRC_W-1:0]   crc_base;
            wire [CW-1:0]       count_base;
            wire [2*N_FUNC-1:0] payload_base;

            assign start  = frame_sync[gi] && !frame_prev[gi];
            assign finish = !frame_sync[gi] && frame_prev[gi];
            // First bit stands on the start edge, so that edge shifts from cleared values
            assign crc_base     = start ? `CRC_INIT : crc;
            assign count_base   = start ? {CW{1'b0}} : count;
            assign payload_base = start ? {2*N_FUNC{1'b0}} : payload;
            assign fb     = crc_base[`CRC_W-1] ^ line_sync[gi];
            // Length, zero remainder and inverted copy all must hold
            assign good   = (count == FRAME_BITS[CW-1:0]) && (crc == `CRC_INIT) &&
                            (payload[2*N_FUNC-1:N_FUNC] == ~payload[N_FUNC-1:0]);

            // Bit capture, one bit per clock while frame is high, start edge included
            always @(posedge clk_sys or negedge rst_sync_b) begin
                if (!rst_sync_b) begin
                    crc     <= `CRC_INIT;
                    count   <= {CW{1'b0}};
                    payload <= {2*N_FUNC{1'b0}};
                end else if (frame_sync[gi]) begin
                    crc <= {crc_base[`CRC_W-2:0], 1'b0} ^ (fb ? `CRC_POLY : {`CRC_W{1'b0}});
                    if (count_base < (2 * N_FUNC))
                        payload <= {payload_base[2*N_FUNC-2:0], line_sync[gi]};
                    // Saturate so an overlong frame is still flagged
                    if (count_base <= FRAME_BITS[CW-1:0])
                        count <= count_base + 1'b1;
                end
            end

            // Storage slot, error bit and arrival supervision
            always @(posedge clk_sys or negedge rst_sync_b) begin
                if (!rst_sync_b) begin
                    slot    <= FAIL_STATE;
                    err     <= 1'b0;
                    fail    <= 1'b1;
                    silence <= 32'h00000000;
                end else if (finish) begin
                    silence <= 32'h00000000;
                    fail    <= 1'b0;
                    if (good) begin
                        slot <= payload[2*N_FUNC-1:N_FUNC];
                        err  <= 1'b0;
                    end else begin
                        slot <= FAIL_STATE;
                        err  <= 1'b1;
                    end
                end else if (silence >= TIMEOUT_CYCLES - 1) begin
                    fail <= 1'b1;
                end else begin
                    silence <= silence + 32'h00000001;
                end
            end

            assign err_w[gi]  = err;
            assign fail_w[gi] = fail;
            // Bad or silent link reads as the failure state
            assign eff_flat[gi*N_FUNC +: N_FUNC] = (err || fail) ? FAIL_STATE : slot;
        end
    endgenerate

    // Two-of-four coincidence, each function bit on its own
    wire [N_FUNC-1:0] va;
    wire [N_FUNC-1:0] vb;
    wire [N_FUNC-1:0] vc;
    wire [N_FUNC-1:0] vd;
    wire [N_FUNC-1:0] vote;

    assign va   = eff_flat[0*N_FUNC +: N_FUNC];
    assign vb   = eff_flat[1*N_FUNC +: N_FUNC];
    assign vc   = eff_flat[2*N_FUNC +: N_FUNC];
    assign vd   = eff_flat[3*N_FUNC +: N_FUNC];
    assign vote = (va & vb) | (va & vc) | (va & vd) |
                  (vb & vc) | (vb & vd) | (vc & vd);

    // Voting cycle scheduler; a stalled buffer defers the push
    reg  [31:0] tick;
    reg         pending;
    reg  [31:0] wd_count;
    wire        buf_ready;
    wire        push;

    assign push = pending && buf_ready;

    always @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tick    <= 32'h00000000;
            pending <= 1'b0;
        end else begin
            if (tick >= VOTE_CYCLES - 1)
                tick <= 32'h00000000;
            else
                tick <= tick + 32'h00000001;
            // New cycle request wins over the push that clears it
            if (tick >= VOTE_CYCLES - 1)
                pending <= 1'b1;
            else if (push)
                pending <= 1'b0;
        end
    end

    // Watchdog: the vote must reach the buffer within the limit
    always @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wd_count <= 32'h00000000;
            wd_alarm <= 1'b0;
        end else if (push) begin
            wd_count <= 32'h00000000;
            wd_alarm <= 1'b0;
        end else if (wd_count >= WD_CYCLES - 1) begin
            wd_alarm <= 1'b1;
        end else begin
            wd_count <= wd_count + 32'h00000001;
        end
    end

    // Registered status outputs
    always @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            link_fail_alarm <= 4'h0;
            err_status      <= 4'h0;
            err_alarm       <= 1'b0;
        end else begin
            link_fail_alarm <= fail_w;
            err_status      <= err_w;
            err_alarm       <= |err_w;
        end
    end

    vote_buffer #(
        .WIDTH      (N_FUNC)
    ) u_vote_buffer (
        .clk_sys    (clk_sys),
        .rst_sync_b (rst_sync_b),
        .in_valid   (pending),
        .in_data    (vote),
        .in_ready   (buf_ready),
        .out_valid  (init_valid),
        .out_data   (init_data),
        .out_ready  (init_ready)
    );

endmodule // coincidence_receiver

// ### tb/coincidence_chk.sv
`timescale 1ns/1ps
module coincidence_chk #(
    parameter N_FUNC         = 8,
    parameter TIMEOUT_CYCLES = 200,
    parameter VOTE_CYCLES    = 20,
    parameter WD_CYCLES      = 100
) (
    // Clock and reset
    input wire              clk_sys,
    input wire              rst_b,
    // Link pins
    input wire [3:0]        link_line,
    input wire [3:0]        link_frame,
    // Voted stream
    input wire [N_FUNC-1:0] init_data,
    input wire              init_valid,
    input wire              init_ready,
    // Status and alarms
    input wire [3:0]        link_fail_alarm,
    input wire [3:0]        err_status,
    input wire              err_alarm,
    input wire              wd_alarm
);
    localparam int WD_CLR    = 2 * VOTE_CYCLES + 4;
    localparam int STALL_LIM = WD_CYCLES + VOTE_CYCLES + 8;
    localparam int TMO_LIM   = TIMEOUT_CYCLES + 8;
    logic [15:0] stall_cnt;
    logic [15:0] idle0;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Stall length and link A quiet time, saturating so a long run never wraps
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stall_cnt <= 16'h0000;
            idle0     <= 16'h0000;
        end else begin
            stall_cnt <= (init_valid && !init_ready) ? stall_cnt + {15'h0000, stall_cnt != 16'hFFFF} : 16'h0000;
            idle0     <= link_frame[0] ? 16'h0000 : idle0 + {15'h0000, idle0 != 16'hFFFF};
        end
    end
    AST_RESET_QUIET: assert property ($rose(rst_b) |-> !init_valid && !wd_alarm && link_fail_alarm == 4'h0)
        else $error("outputs not quiet at reset release");
    AST_START_FAILED: assert property ($rose(rst_b) |-> ##[1:5] link_fail_alarm == 4'hF)
        else $error("links not failed after reset");
    AST_TIMEOUT: assert property (idle0 == TMO_LIM |-> link_fail_alarm[0])
        else $error("quiet link not flagged failed");
    AST_FAIL_CLEARS: assert property ($fell(link_fail_alarm[0]) |-> idle0 <= 16'h0008)
        else $error("fail alarm cleared without a frame");
    AST_ERR_CAUSE: assert property ($rose(err_status[0]) |-> idle0 <= 16'h0008)
        else $error("error bit set without a frame end");
    AST_ERR_ALARM: assert property (err_status != 4'h0 |-> ##[0:1] err_alarm)
        else $error("error bit without alarm");
    AST_ALL_FAIL_VOTE: assert property ($rose(init_valid) && (&link_fail_alarm) && (&($past(link_fail_alarm, 3)))
        |-> init_data == {N_FUNC{1'b1}})
        else $error("failed links not voted as fail state");
    AST_VALID_HOLD: assert property (init_valid && !init_ready |=> init_valid && $stable(init_data))
        else $error("stalled word changed");
    AST_WD_SET: assert property (stall_cnt == STALL_LIM |-> wd_alarm)
        else $error("watchdog silent on stalled cycle");
    AST_WD_CLEAR: assert property (wd_alarm && init_valid && init_ready |-> ##[1:WD_CLR] !wd_alarm)
        else $error("watchdog not cleared after cycle resumed");
    // Main scenarios reached
    CV_TAKE: cover property (init_valid && init_ready);
    CV_ERR: cover property ($rose(err_status[0]));
    CV_WD: cover property ($rose(wd_alarm));
endmodule // coincidence_chk

bind coincidence_receiver coincidence_chk #(.N_FUNC(N_FUNC), .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
    .VOTE_CYCLES(VOTE_CYCLES), .WD_CYCLES(WD_CYCLES)) chk_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .link_line(link_line), .link_frame(link_frame), .init_data(init_data), .init_valid(init_valid),
    .init_ready(init_ready), .link_fail_alarm(link_fail_alarm), .err_status(err_status),
    .err_alarm(err_alarm), .wd_alarm(wd_alarm));

// ### tb/link_partner.sv
`timescale 1ns/1ps
module link_partner (
    // Clock
    input  wire        clk_sys,
    // Link pins, bit 0 is link A
    output logic [3:0] link_line,
    output logic [3:0] link_frame
);
    // Lines parked until the first frame
    initial begin
        link_line  = 4'h0;
        link_frame = 4'h0;
    end
    // CRC-8, poly 0x07, MSB first
    function automatic logic [7:0] crc8(input logic [15:0] m);
        crc8 = 8'h00;
        for (int j = 15; j >= 0; j--)
            crc8 = {crc8[6:0], 1'b0} ^ ((crc8[7] ^ m[j]) ? 8'h07 : 8'h00);
    endfunction
    // Every link sent at once; code 1 bad CRC, 2 bad copy, 3 one bit short
    task send(input logic [31:0] d, input logic [7:0] bad);
        logic [23:0] f [4];
        logic [7:0]  cp;
        for (int i = 0; i < 4; i++) begin
            cp   = ~d[8*i+:8] ^ {7'h00, bad[2*i+:2] == 2'h2};
            f[i] = {d[8*i+:8], cp, crc8({d[8*i+:8], cp}) ^ {7'h00, bad[2*i+:2] == 2'h1}};
        end
        for (int k = 23; k >= 0; k--) begin
            @(posedge clk_sys) #1;
            for (int i = 0; i < 4; i++) begin
                link_line[i]  = f[i][k];
                link_frame[i] = !(k == 0 && bad[2*i+:2] == 2'h3);
            end
        end
        // Released line shows the inverse, never a stale level
        @(posedge clk_sys) #1;
        link_frame = 4'h0;
        link_line  = ~link_line;
    endtask
endmodule // link_partner

// ### tb/two_of_four_coincidence_receiver_tb.sv
`timescale 1ns/1ps
module two_of_four_coincidence_receiver_tb;
    localparam int TMO  = 200;
    localparam int VOTE = 20;
    localparam int WD   = 100;
    // Bench signals
    logic       clk_sys      = 1'b0;
    logic       rst_b        = 1'b0;
    logic       init_ready   = 1'b1;
    wire  [3:0] link_line;
    wire  [3:0] link_frame;
    wire  [7:0] init_data;
    wire        init_valid;
    wire  [3:0] link_fail_alarm;
    wire  [3:0] err_status;
    wire        err_alarm;
    wire        wd_alarm;
    int         bad_count    = 0;
    int         total_checks = 0;
    int         cyc          = 0;
    logic [7:0] v;
    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;
    link_partner partner_u (.clk_sys(clk_sys), .link_line(link_line), .link_frame(link_frame));
    // Short counts keep the run brief
    coincidence_receiver #(.TIMEOUT_CYCLES(TMO), .VOTE_CYCLES(VOTE), .WD_CYCLES(WD)) dut_u (.clk_sys(clk_sys),
        .rst_b(rst_b), .link_line(link_line), .link_frame(link_frame), .init_data(init_data),
        .init_valid(init_valid), .init_ready(init_ready), .link_fail_alarm(link_fail_alarm),
        .err_status(err_status), .err_alarm(err_alarm), .wd_alarm(wd_alarm));
    task summarize;
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Drain stale words, then take the next fresh one
    task get_vote(output logic [7:0] w);
        tick(2 * VOTE);
        while (init_valid !== 1'b1) tick(1);
        w = init_data;
        tick(1);
    endtask
    function automatic logic [7:0] vote2(input logic [31:0] e);
        logic [7:0] a, b, c, d;
        {d, c, b, a} = e;
        vote2 = (a & b) | (a & c) | (a & d) | (b & c) | (b & d) | (c & d);
    endfunction
    task t_start;
        tick(5);
        check8({4'h0, link_fail_alarm}, 8'h0F);
        get_vote(v);
        check8(v, 8'hFF);
    endtask
    // First word gives each pair one bit of its own
    task t_vote;
        logic [39:0] tab [5];
        logic [31:0] eff;
        logic [3:0]  em;
        tab = '{40'h34_2A_99_47_00, 40'h00_F0_0F_3C_01, 40'h34_2A_99_47_08, 40'h81_18_42_24_C0, 40'hA5_5A_00_FF_00};
        for (int n = 0; n < 5; n++) begin
            partner_u.send(tab[n][39:8], tab[n][7:0]);
            for (int i = 0; i < 4; i++) begin
                em[i]       = |tab[n][2*i+:2];
                eff[8*i+:8] = em[i] ? 8'hFF : tab[n][8+8*i+:8];
            end
            tick(6);
            check8({4'h0, err_status}, {4'h0, em});
            check8({7'h00, err_alarm}, {7'h00, |em});
            check8({4'h0, link_fail_alarm}, 8'h00);
            get_vote(v);
            check8(v, vote2(eff));
        end
    endtask
    task t_timeout;
        tick(TMO + 10);
        check8({4'h0, link_fail_alarm}, 8'h0F);
        get_vote(v);
        check8(v, 8'hFF);
        partner_u.send(32'h00_F0_0F_3C, 8'h00);
        tick(6);
        check8({4'h0, link_fail_alarm}, 8'h00);
        get_vote(v);
        check8(v, 8'h3C);
    endtask
    // Sink stalls past the watchdog limit, then resumes
    task t_stall;
        partner_u.send(32'h00_00_00_00, 8'h00);
        // Let the all-clear frame reach the slots before the sink stalls
        tick(6);
        init_ready = 1'b0;
        tick(2 * VOTE);
        tick(WD + VOTE);
        check8({7'h00, wd_alarm}, 8'h01);
        check8({7'h00, init_valid}, 8'h01);
        check8(init_data, 8'h00);
        init_ready = 1'b1;
        tick(2 * VOTE + 6);
        check8({7'h00, wd_alarm}, 8'h00);
    endtask
    // Hang guard, well above the expected run
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        tick(3);
        rst_b = 1'b1;
        t_start();
        t_vote();
        t_timeout();
        t_stall();
        summarize();
    end
endmodule // two_of_four_coincidence_receiver_tb
